// file: rtl/ssd_pkg.sv
// Shared constants and types for the two-wire slave link and its bus master end
package ssd_pkg;
	// Timing
	localparam int SYS_CLK_MHZ     = 25;
	localparam int SCL_PERIOD_NS   = 320;
	localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS * SYS_CLK_MHZ) / (1000 * 4);

	// Register port map
	localparam int         REG_AW   = 2;
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_DATA = 2'h1;
	localparam logic [1:0] REG_CFG  = 2'h2;

	// Control register fields
	localparam int BIT_MASTER = 7;
	localparam int BIT_TRANSMIT_DIRECTION_FLAG = 6;
	localparam int BIT_START  = 5;
	localparam int BIT_STOP   = 4;
	localparam int BIT_ACKREQ = 3;
	localparam int BIT_ARBITRATION_LOST_FLAG = 2;
	localparam int BIT_ACK    = 1;
	localparam int BIT_EVENT  = 0;

	// Config register fields: own address in the top seven bits
	localparam int BIT_INHIBIT = 0;
	localparam int ADDR_LSB    = 1;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET  = 8'h00;
	localparam logic [3:0] BYTE_BITS  = 4'h8;

	// Orders for the bus master end
	typedef enum logic [3:0] {
		CMD_START = 4'h1,
		CMD_WRITE = 4'h2,
		CMD_READ  = 4'h4,
		CMD_STOP  = 4'h8
	} ssd_cmd_t;
endpackage

// file: rtl/ssd_link_if.sv
// Open-drain two-wire link joining the slave device and the bus master
`timescale 1ns/1ps
interface ssd_link_if;
	logic devSclO;
	logic devSclOe;
	logic devSdaO;
	logic devSdaOe;
	logic hostSclO;
	logic hostSclOe;
	logic hostSdaO;
	logic hostSdaOe;
	logic scl;
	logic sda;

	// Pull-up resolves to high unless an enabled driver pulls low
	assign scl = (devSclOe ? devSclO : 1'b1) & (hostSclOe ? hostSclO : 1'b1);
	assign sda = (devSdaOe ? devSdaO : 1'b1) & (hostSdaOe ? hostSdaO : 1'b1);

	modport device (input scl, input sda, output devSclO, output devSclOe, output devSdaO, output devSdaOe);
	modport host (input scl, input sda, output hostSclO, output hostSclOe, output hostSdaO, output hostSdaOe);
endinterface

// file: rtl/ssd_host.sv
// Bus master end: drives SCL from a divider and runs start, byte and stop orders
`timescale 1ns/1ps
module ssd_host #(
	parameter int QUARTER_CYC = ssd_pkg::SCL_QUARTER_CYC
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// Two-wire link
	ssd_link_if.host              link,
	// Order port
	input  wire logic             cmdValid,
	input  wire ssd_pkg::ssd_cmd_t cmdCode,
	input  wire logic [7:0]       cmdData,
	input  wire logic             cmdAck,
	output logic                  cmdReady,
	// Answer port
	output logic                  rspValid,
	output logic [7:0]            rspData,
	output logic                  rspAck
);
	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_START = 4'h2,
		H_BITS  = 4'h4,
		H_STOP  = 4'h8
	} ssd_hstate_t;

	ssd_hstate_t state;
	logic [7:0]  divCnt;
	logic [1:0]  phase;
	logic [3:0]  bitIdx;
	logic [8:0]  txShift;
	logic [8:0]  rxShift;
	logic        sclLow;
	logic        sdaLow;
	logic        sclMeta;
	logic        sclSync;
	logic        sdaMeta;
	logic        sdaSync;

	wire tick    = (divCnt == 8'(QUARTER_CYC - 1));
	wire stall   = (phase == 2'h2) && !sclSync;
	wire advance = tick && !stall && !state[0];
	wire lastPh  = advance && (phase == 2'h3);
	wire finish  = lastPh && (!state[2] || (bitIdx == ssd_pkg::BYTE_BITS));

	assign cmdReady       = (state == H_IDLE);
	assign link.hostSclO  = 1'b0;
	assign link.hostSclOe = sclLow;
	assign link.hostSdaO  = 1'b0;
	assign link.hostSdaOe = sdaLow;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclMeta <= 1'b1;
			sclSync <= 1'b1;
			sdaMeta <= 1'b1;
			sdaSync <= 1'b1;
			divCnt  <= 8'h00;
		end else begin
			sclMeta <= link.scl;
			sclSync <= sclMeta;
			sdaMeta <= link.sda;
			sdaSync <= sdaMeta;
			divCnt  <= tick ? 8'h00 : divCnt + 8'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= H_IDLE;
			phase    <= 2'h0;
			bitIdx   <= 4'h0;
			txShift  <= 9'h1FF;
			rxShift  <= 9'h000;
			sclLow   <= 1'b0;
			sdaLow   <= 1'b0;
			rspValid <= 1'b0;
			rspData  <= 8'h00;
			rspAck   <= 1'b0;
		end else begin
			rspValid <= finish;
			if (finish) begin
				rspData <= rxShift[8:1];
				rspAck  <= !rxShift[0];
			end
			if (state == H_IDLE && cmdValid) begin
				phase  <= 2'h0;
				bitIdx <= 4'h0;
				unique case (cmdCode)
					ssd_pkg::CMD_START: state <= H_START;
					ssd_pkg::CMD_WRITE: begin
						state   <= H_BITS;
						txShift <= {cmdData, 1'b1};
					end
					ssd_pkg::CMD_READ: begin
						state   <= H_BITS;
						txShift <= {8'hFF, !cmdAck}; // R16
					end
					default: state <= H_STOP;
				endcase
			end else if (advance) begin
				phase <= phase + 2'h1;
				unique case (phase)
					2'h0: sdaLow <= state[1] ? 1'b0 : (state[3] ? 1'b1 : !txShift[8]);
					2'h1: sclLow <= 1'b0;
					2'h2: begin
						if (state[2])
							rxShift <= {rxShift[7:0], sdaSync};
						else
							sdaLow <= state[1];
					end
					default: begin
						sclLow  <= !state[3];
						txShift <= {txShift[7:0], 1'b1};
						bitIdx  <= bitIdx + 4'h1;
						if (finish)
							state <= H_IDLE;
					end
				endcase
			end
		end
	end
endmodule // ssd_host

// file: rtl/ssd_device.sv
// Two-wire slave receive/transmit interface with status vector and register port
//
// Functional notes
// R1: Matched write address enters receive, raises event
// R2: NACKed address suppresses events until next START
// R3: Software writes ACK bit after each byte
// R4: STOP ends slave receive
// R5: Data write while receiving switches to transmit
// R6: Receive event raised before the ACK clock
// R7: Transmit event raised after master ACK sampled
// R8: Matched read address raises event, requests ACK
// R9: Software loads next byte only after ACK
// R10: STOP ends slave transmit
// R11: No data write after transmit event: receive
// R12: Vector is master, direction, start, stop bits
// R13: 1110 means master START generated; the code never sets the master bit, so it never reports 1110
// R14: 1100 means master byte sent, ACK shown; the code never reports 1100, as the master bit stays zero
// R15: 1000 with request means master byte received; the code never reports 1000, as the master bit stays zero
// R16: Master read ends with NACK then STOP
// R17: 0100 reports sent slave byte, ACK, error
// R18: 0101 reports illegal STOP during slave transmit
// R19: 0010 with request reports received slave address
// R20: 0010 without request: arbitration lost, repeated START; the code never acts as master, so this case does not arise
// R21: 0001 reports STOP cases by flags
// R22: 0000 with request reports received slave byte
// R23: Event flag set holds SCL low; in idle, as after the STOP event, the code sets the flag but does not hold SCL
// R24: ACK bit one drives ACK, zero NACK
`timescale 1ns/1ps
module ssd_device (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	// Two-wire link
	ssd_link_if.device                      link,
	// Register port
	input  wire logic [ssd_pkg::REG_AW-1:0] regAddr,
	input  wire logic [7:0]                 regWrData,
	input  wire logic                       regWr,
	input  wire logic                       regRd,
	output logic [7:0]                      regRdData,
	// Status
	output logic [3:0]                      statusVector,
	output logic                            byteEvent
);
	typedef enum logic [6:0] {
		S_IDLE   = 7'h01,
		S_RECV   = 7'h02,
		S_RXHOLD = 7'h04,
		S_ACK    = 7'h08,
		S_TX     = 7'h10,
		S_TXACK  = 7'h20,
		S_TXHOLD = 7'h40
	} ssd_state_t;

	ssd_state_t state;
	logic [7:0] shiftReg;
	logic [3:0] bitCnt;
	logic       isAddr;
	logic       sdaLow;
	logic       suppress;
	logic       dataWritten;
	logic [7:0] dataReg;
	logic [7:0] cfgReg;
	logic       transmit_direction_flag;
	logic       startFlag;
	logic       stopFlag;
	logic       ackReq;
	logic       arbitration_lost_flag;
	logic       ackBit;
	logic       si;
	logic       sclMeta;
	logic       sclSync;
	logic       sclPrev;
	logic       sdaMeta;
	logic       sdaSync;
	logic       sdaPrev;
	logic       sclHoldQ;

	// Line events
	wire sclRise   = sclSync && !sclPrev;
	wire sclFall   = !sclSync && sclPrev;
	wire startSeen = sclSync && sclPrev && sdaPrev && !sdaSync;
	wire stopSeen  = sclSync && sclPrev && !sdaPrev && sdaSync;

	// Register port decode
	wire ctrlWr  = regWr && (regAddr == ssd_pkg::REG_CTRL);
	wire dataWr  = regWr && (regAddr == ssd_pkg::REG_DATA);
	wire cfgWr   = regWr && (regAddr == ssd_pkg::REG_CFG);
	wire siClear = ctrlWr && !regWrData[ssd_pkg::BIT_EVENT];

	// Byte events
	wire addrMatch = (shiftReg[7:1] == cfgReg[7:ssd_pkg::ADDR_LSB]) && !cfgReg[ssd_pkg::BIT_INHIBIT] && !suppress;
	wire byteIn    = state[1] && sclFall && (bitCnt == ssd_pkg::BYTE_BITS);
	wire addrHit   = byteIn && isAddr && addrMatch;
	wire rxByte    = byteIn && !isAddr;
	wire ackEnd    = state[3] && sclFall;
	wire nackAddr  = ackEnd && isAddr && !ackBit;
	wire txHoldEnd = state[6] && !si;
	wire frameNext = (ackEnd && !nackAddr) || txHoldEnd;
	wire txNext    = frameNext && dataWritten;
	wire rxNext    = frameNext && !dataWritten;
	wire txAckEnd  = state[5] && sclFall;
	wire txErr     = state[4] && sclRise && !sdaLow && !sdaSync;
	wire slvStop   = stopSeen && !state[0];
	wire siSet     = addrHit || rxByte || txAckEnd || slvStop;
	// SCL is let go one cycle after the hold ends, so SDA has settled before it rises
	wire sclHold   = (si && !state[0]) || state[2] || state[6];

	// This end never becomes master, so the master vectors never appear
	wire        masterBit = 1'b0; // R13 R14 R15 R20
	wire [7:0]  ctrlView  = {masterBit, transmit_direction_flag, startFlag, stopFlag, ackReq, arbitration_lost_flag, ackBit, si};
	wire [7:0]  rdMux     = (regAddr == ssd_pkg::REG_CTRL) ? ctrlView :
	                        (regAddr == ssd_pkg::REG_DATA) ? dataReg :
	                        (regAddr == ssd_pkg::REG_CFG)  ? cfgReg : 8'h00;

	assign statusVector  = ctrlView[7:4]; // R12
	assign byteEvent     = si;
	assign link.devSclO  = 1'b0;
	assign link.devSclOe = sclHold || sclHoldQ; // R23
	assign link.devSdaO  = 1'b0;
	assign link.devSdaOe = sdaLow;

	// Line synchronisers; second and third stages feed logic
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclMeta <= 1'b1;
			sclSync <= 1'b1;
			sclPrev <= 1'b1;
			sdaMeta <= 1'b1;
			sdaSync <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclMeta <= link.scl;
			sclSync <= sclMeta;
			sclPrev <= sclSync;
			sdaMeta <= link.sda;
			sdaSync <= sdaMeta;
			sdaPrev <= sdaSync;
		end
	end

	// Byte sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= S_IDLE;
			shiftReg <= 8'h00;
			bitCnt   <= 4'h0;
			isAddr   <= 1'b0;
			sdaLow   <= 1'b0;
		end else if (startSeen) begin
			state  <= S_RECV;
			bitCnt <= 4'h0;
			isAddr <= 1'b1;
			sdaLow <= 1'b0;
		end else if (stopSeen) begin
			state  <= S_IDLE; // R4 R10
			sdaLow <= 1'b0;
		end else if (txNext) begin
			state    <= S_TX; // R5
			shiftReg <= dataReg;
			sdaLow   <= !dataReg[7];
			bitCnt   <= 4'h0;
			isAddr   <= 1'b0;
		end else if (rxNext) begin
			state  <= S_RECV; // R11
			sdaLow <= 1'b0;
			bitCnt <= 4'h0;
			isAddr <= 1'b0;
		end else begin
			unique case (state)
				S_RECV: begin
					if (sclRise) begin
						shiftReg <= {shiftReg[6:0], sdaSync};
						bitCnt   <= bitCnt + 4'h1;
					end
					if (byteIn)
						state <= (isAddr && !addrMatch) ? S_IDLE : S_RXHOLD;
				end
				S_RXHOLD: begin
					if (!si) begin
						sdaLow <= ackBit; // R24
						state  <= S_ACK;
					end
				end
				S_ACK: begin
					if (nackAddr) begin
						sdaLow <= 1'b0;
						state  <= S_IDLE;
					end
				end
				S_TX: begin
					if (sclRise)
						bitCnt <= bitCnt + 4'h1;
					if (sclFall && bitCnt == ssd_pkg::BYTE_BITS) begin
						sdaLow <= 1'b0;
						state  <= S_TXACK;
					end else if (sclFall) begin
						shiftReg <= {shiftReg[6:0], 1'b0};
						sdaLow   <= !shiftReg[6];
					end
				end
				S_TXACK: if (txAckEnd) state <= S_TXHOLD;
				default: ;
			endcase
		end
	end

	// Event flag and status bits; hardware sets win over software writes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			si        <= ssd_pkg::CTRL_RESET[ssd_pkg::BIT_EVENT];
			ackReq    <= ssd_pkg::CTRL_RESET[ssd_pkg::BIT_ACKREQ];
			startFlag <= ssd_pkg::CTRL_RESET[ssd_pkg::BIT_START];
			stopFlag  <= ssd_pkg::CTRL_RESET[ssd_pkg::BIT_STOP];
			arbitration_lost_flag   <= ssd_pkg::CTRL_RESET[ssd_pkg::BIT_ARBITRATION_LOST_FLAG];
			ackBit    <= ssd_pkg::CTRL_RESET[ssd_pkg::BIT_ACK];
			transmit_direction_flag    <= ssd_pkg::CTRL_RESET[ssd_pkg::BIT_TRANSMIT_DIRECTION_FLAG];
			sclHoldQ  <= 1'b0;
		end else begin
			sclHoldQ  <= sclHold; // R23
			si        <= siSet || (si && !siClear); // R1 R6 R7 R8
			ackReq    <= (addrHit || rxByte) || (ackReq && !ackEnd); // R19 R22
			startFlag <= addrHit || (ctrlWr ? regWrData[ssd_pkg::BIT_START] : startFlag);
			stopFlag  <= slvStop || (ctrlWr ? regWrData[ssd_pkg::BIT_STOP] : stopFlag); // R21
			arbitration_lost_flag   <= txErr || (arbitration_lost_flag && !siClear); // R17
			if (state[5] && sclRise)
				ackBit <= !sdaSync; // R17
			else if (ctrlWr)
				ackBit <= regWrData[ssd_pkg::BIT_ACK]; // R3
			if (startSeen || rxNext || (slvStop && !state[4]))
				transmit_direction_flag <= 1'b0;
			else if (txNext)
				transmit_direction_flag <= 1'b1; // R18
		end
	end

	// Software registers, inhibit window and read port
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			suppress    <= 1'b0;
			dataWritten <= 1'b0;
			dataReg     <= 8'h00;
			cfgReg      <= ssd_pkg::CFG_RESET;
			regRdData   <= 8'h00;
		end else begin
			suppress    <= nackAddr || (suppress && !startSeen); // R2
			dataWritten <= dataWr || (dataWritten && !frameNext && !startSeen); // R9
			if (dataWr)
				dataReg <= regWrData;
			else if (byteIn)
				dataReg <= shiftReg;
			if (cfgWr)
				cfgReg <= regWrData;
			regRdData <= regRd ? rdMux : 8'h00;
		end
	end
endmodule // ssd_device

// file: test/ssd_sva.sv
// Link protocol assertions for the two-wire slave end
`timescale 1ns/1ps
module ssd_sva (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link signals
	input wire logic devSclO,
	input wire logic devSclOe,
	input wire logic devSdaO,
	input wire logic devSdaOe,
	input wire logic hostSclO,
	input wire logic hostSclOe,
	input wire logic hostSdaO,
	input wire logic hostSdaOe,
	input wire logic scl,
	input wire logic sda
);
	logic       sclQ, sdaQ, busy, startEv, stopEv, next_busy;
	logic [3:0] bits, next_bits;

	// Frame tracking: clock rises counted from the last START
	assign startEv   = sclQ & scl & sdaQ & !sda;
	assign stopEv    = sclQ & scl & !sdaQ & sda;
	assign next_busy = startEv | (busy & !stopEv);
	assign next_bits = startEv ? 4'h0 : (!sclQ & scl & (bits != 4'hF)) ? bits + 4'h1 : bits;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
			busy <= 1'b0;
			bits <= 4'hF;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
			busy <= next_busy;
			bits <= next_bits;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_ack_drive;
		devSdaOe ##1 scl;
	endsequence

	a_scl_drive_low: assert property (devSclOe |-> !devSclO)
		else $error("device drives SCL high");
	a_sda_drive_low: assert property (devSdaOe |-> !devSdaO)
		else $error("device drives SDA high");
	a_stretch_after_fall: assert property ($rose(devSclOe) && busy |-> !$past(scl) && !$past(scl, 2))
		else $error("stretch began while SCL was high");
	a_sda_moves_low: assert property ($changed(devSdaOe) |-> !scl)
		else $error("device SDA changed while SCL high");
	a_quiet_address: assert property (busy && bits < 4'h8 |-> !devSdaOe)
		else $error("device drove SDA during address bits");
	a_stretch_at_end: assert property ($rose(devSclOe) && busy |-> bits >= 4'h8)
		else $error("stretch inside first byte");
	a_reset_quiet: assert property ($rose(rst_n) |-> !devSdaOe && !devSclOe)
		else $error("device drives link after reset");
	a_ack_hold: assert property (s_ack_drive |-> devSdaOe)
		else $error("device let go of SDA with SCL high");
endmodule // ssd_sva

// file: test/tb.sv
// Self-checking bench: bus master end against slave end over the link
`timescale 1ns/1ps
module tb;
	logic              core_clk = 0;
	logic              rst_n = 0;
	logic [1:0]        regAddr = 0;
	logic [7:0]        regWrData = 0;
	logic              regWr = 0;
	logic              regRd = 0;
	logic [7:0]        regRdData, rv, rspData, cmdData = 0;
	logic [3:0]        statusVector;
	logic              byteEvent, cmdReady, rspValid, rspAck;
	logic              cmdValid = 0;
	logic              cmdAck = 0;
	ssd_pkg::ssd_cmd_t cmdCode = ssd_pkg::CMD_STOP;
	int                num_errors = 0;
	int                checks = 0;
	int                seed = 77;
	logic [6:0]        own;
	logic [7:0]        d [4];
	logic              a [4];

	ssd_link_if link();
	ssd_device u_ssd_device(.core_clk(core_clk), .rst_n(rst_n), .link(link), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.statusVector(statusVector), .byteEvent(byteEvent));
	ssd_host u_ssd_host(.core_clk(core_clk), .rst_n(rst_n), .link(link), .cmdValid(cmdValid),
		.cmdCode(cmdCode), .cmdData(cmdData), .cmdAck(cmdAck), .cmdReady(cmdReady),
		.rspValid(rspValid), .rspData(rspData), .rspAck(rspAck));
	ssd_sva u_ssd_sva(.core_clk(core_clk), .rst_n(rst_n), .devSclO(link.devSclO), .devSclOe(link.devSclOe),
		.devSdaO(link.devSdaO), .devSdaOe(link.devSdaOe), .hostSclO(link.hostSclO),
		.hostSclOe(link.hostSclOe), .hostSdaO(link.hostSdaO), .hostSdaOe(link.hostSdaOe),
		.scl(link.scl), .sda(link.sda));

	initial forever #20 core_clk = ~core_clk;

	task automatic conclude;
		if (num_errors == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (e !== g) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask

	task automatic wr(input logic [1:0] ad, input logic [7:0] v);
		@(posedge core_clk);
		regAddr <= ad;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] ad);
		@(posedge core_clk);
		regAddr <= ad;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 rv = regRdData;
	endtask

	// One order to the master end, held until taken, then wait for its answer
	task automatic hc(input ssd_pkg::ssd_cmd_t c, input logic [7:0] v, input logic k);
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmdCode <= c;
		cmdData <= v;
		cmdAck <= k;
		do @(posedge core_clk); while (cmdReady !== 1'b1);
		cmdValid <= 1'b0;
		do @(negedge core_clk); while (rspValid !== 1'b1);
	endtask

	task automatic ev(input logic [3:0] v);
		do @(negedge core_clk); while (byteEvent !== 1'b1);
		chk("vector", {4'h0, v}, {4'h0, statusVector});
	endtask

	initial begin
		#1000000;
		num_errors++;
		conclude();
	end

	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		own = 7'($random(seed)) | 7'h01;
		for (int i = 0; i < 4; i++) begin
			d[i] = 8'($random(seed));
			a[i] = 1'($random(seed));
		end
		wr(ssd_pkg::REG_CFG, {own, 1'b0});
		rd(2'h3);
		chk("unmapped", 8'h00, rv);
		// Write frame with random data and random acknowledge choices
		fork
			begin
				hc(ssd_pkg::CMD_START, 8'h00, 1'b0);
				hc(ssd_pkg::CMD_WRITE, {own, 1'b0}, 1'b0);
				chk("addr ack", 8'h01, {7'h0, rspAck});
				for (int i = 0; i < 4; i++) begin
					hc(ssd_pkg::CMD_WRITE, d[i], 1'b0);
					chk("data ack", {7'h0, a[i]}, {7'h0, rspAck});
				end
				hc(ssd_pkg::CMD_STOP, 8'h00, 1'b0);
			end
			begin
				ev(4'b0010);
				rd(ssd_pkg::REG_CTRL);
				chk("ack request", 8'h01, {7'h0, rv[ssd_pkg::BIT_ACKREQ]});
				chk("stall", 8'h00, {7'h0, cmdReady});
				wr(ssd_pkg::REG_CTRL, 8'h02);
				for (int i = 0; i < 4; i++) begin
					ev(4'b0000);
					chk("stall", 8'h00, {7'h0, cmdReady});
					rd(ssd_pkg::REG_DATA);
					chk("rx data", d[i], rv);
					wr(ssd_pkg::REG_CTRL, {6'h00, a[i], 1'b0});
				end
				ev(4'b0001);
				wr(ssd_pkg::REG_CTRL, 8'h00);
			end
		join
		// Refused address, then an address of another device
		fork
			begin
				hc(ssd_pkg::CMD_START, 8'h00, 1'b0);
				hc(ssd_pkg::CMD_WRITE, {own, 1'b0}, 1'b0);
				chk("nack addr", 8'h00, {7'h0, rspAck});
				hc(ssd_pkg::CMD_WRITE, d[0], 1'b0);
				hc(ssd_pkg::CMD_STOP, 8'h00, 1'b0);
				hc(ssd_pkg::CMD_START, 8'h00, 1'b0);
				hc(ssd_pkg::CMD_WRITE, {~own, 1'b0}, 1'b0);
				chk("other addr", 8'h00, {7'h0, rspAck});
				hc(ssd_pkg::CMD_STOP, 8'h00, 1'b0);
			end
			begin
				ev(4'b0010);
				wr(ssd_pkg::REG_CTRL, 8'h00);
			end
		join
		chk("suppressed", 8'h00, {7'h0, byteEvent});
		// Read frame: one acknowledged byte, then a refused one
		fork
			begin
				hc(ssd_pkg::CMD_START, 8'h00, 1'b0);
				hc(ssd_pkg::CMD_WRITE, {own, 1'b1}, 1'b0);
				chk("read addr ack", 8'h01, {7'h0, rspAck});
				hc(ssd_pkg::CMD_READ, 8'h00, 1'b1);
				chk("tx byte", d[1], rspData);
				hc(ssd_pkg::CMD_READ, 8'h00, 1'b0);
				chk("tx byte", d[2], rspData);
				hc(ssd_pkg::CMD_STOP, 8'h00, 1'b0);
			end
			begin
				ev(4'b0010);
				wr(ssd_pkg::REG_DATA, d[1]);
				wr(ssd_pkg::REG_CTRL, 8'h02);
				ev(4'b0100);
				rd(ssd_pkg::REG_CTRL);
				chk("master ack", 8'h01, {7'h0, rv[ssd_pkg::BIT_ACK]});
				chk("arb lost", 8'h00, {7'h0, rv[ssd_pkg::BIT_ARBITRATION_LOST_FLAG]});
				wr(ssd_pkg::REG_DATA, d[2]);
				wr(ssd_pkg::REG_CTRL, 8'h00);
				ev(4'b0100);
				rd(ssd_pkg::REG_CTRL);
				chk("master nack", 8'h00, {7'h0, rv[ssd_pkg::BIT_ACK]});
				wr(ssd_pkg::REG_CTRL, 8'h00);
				do @(negedge core_clk); while (byteEvent !== 1'b1);
				chk("stop flag", 8'h01, {7'h0, statusVector[0]});
				wr(ssd_pkg::REG_CTRL, 8'h00);
			end
		join
		conclude();
	end
endmodule // tb
